/* inc/sap_pkg.sv */
// Shared constants, types and helpers for the stereo audio serial port
package sap_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 16;
  localparam int DIV_W = 8;
  localparam int NPORT = 2;
  localparam int MEM_DEPTH = 128;
  localparam int RING_AW = 6;
  localparam logic [RING_AW:0] RING_SIZE = 7'h40;
  localparam logic [RING_AW:0] PTR_ONE = 7'h01;
  localparam logic HALF_TX = 1'h0;
  localparam logic HALF_RX = 1'h1;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT1 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TXDATA0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TXDATA1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RXDATA0 = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RXDATA1 = 8'h1C;
  // Control field positions
  localparam int CB_EN = 0;
  localparam int CB_MASTER = 1;
  localparam int CB_MCLK_INT = 2;
  localparam int CB_SPDIF = 3;
  localparam int CB_WL_LO = 4;
  localparam int CB_DIV_LO = 8;
  // Status field positions and sticky flag indices
  localparam int ST_TXCNT_LO = 0;
  localparam int ST_RXCNT_LO = 8;
  localparam int ST_FLAG_LO = 16;
  localparam int ST_BYTE = 2;
  localparam int F_UNDER = 0;
  localparam int F_OVER = 1;
  localparam int F_DROP = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WL_16 = 2'b00, WL_20 = 2'b01, WL_24 = 2'b10, WL_32 = 2'b11} sap_wl_t;
  // Bits per channel word for a length code
  function automatic logic [5:0] sap_wl_bits(input logic [1:0] c);
    case (sap_wl_t'(c))
      WL_16: return 6'h10;
      WL_20: return 6'h14;
      WL_24: return 6'h18;
      default: return 6'h20;
    endcase
  endfunction
  // Left-justify an n-bit received word into 32 bits
  function automatic logic [DATA_W-1:0] sap_justify(input logic [DATA_W-1:0] v, input logic [5:0] n);
    return v << (6'h20 - n);
  endfunction
endpackage

/* hw/sap_top.sv */
// Stereo audio serial port: link serializer and AXI4-Lite sample buffer top
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
module sap_link import sap_pkg::*; (
  input wire logic lclk, // Link (oversample source) clock
  input wire logic srst, // System reset, synchronised here
  input wire logic [CTRL_W-1:0] cfg, // Quasi-static control word
  input wire logic [DATA_W-1:0] hold_word, // Next transmit word
  input wire logic ack_tgl, // Toggles when hold_word is fresh
  output logic req_tgl, // Toggles to ask for a word
  output logic rx_tgl, // Toggles when rx_word is fresh
  output logic [DATA_W-1:0] rx_word, // Last received word
  output logic bclk_o, // Bit clock drive
  output logic bclk_oe, // Bit clock enable
  input wire logic bclk_i, // Bit clock pin
  output logic ws_o, // Word select drive
  output logic ws_oe, // Word select enable
  input wire logic ws_i, // Word select pin
  output logic sdo, // Serial data out
  input wire logic sdi, // Serial data in
  output logic osc_o, // Oversample clock drive
  output logic osc_oe // Oversample clock enable
);
  typedef struct packed {
    logic [7:0] div_cnt;
    logic [5:0] bitpos;
    logic bclk, ws_m, ws_lf, ws_lr, ws_lt, pre, sdo, req, rx_t, run, rx_run;
    logic osc, osc_oe, bclk_oe, ws_oe;
    logic [DATA_W-1:0] tx_sr, next_w, rx_sr, rxw;
  } sap_lfun_t;
  typedef struct packed {
    logic [1:0] rst_s;
    logic [CTRL_W-1:0] cfg_s1, cfg_s2;
    logic [2:0] bck_s, ack_s;
    logic [1:0] ws_s, sdi_s;
    sap_lfun_t f;
  } sap_lstate_t;
  sap_lstate_t l_q, l_d;
  logic master, active, tick, rise_ev, fall_ev, ws_cur, lrst, rx_rise, ws_pin;
  logic [5:0] wlen;
  logic [DIV_W-1:0] div;
  logic [DATA_W-1:0] rx_next;

  // Decoded configuration and bit-clock edge events
  assign lrst = l_q.rst_s[1];
  assign master = l_q.cfg_s2[CB_MASTER];
  assign active = l_q.cfg_s2[CB_EN] && !l_q.cfg_s2[CB_SPDIF];
  assign wlen = sap_wl_bits(l_q.cfg_s2[CB_WL_LO +: 2]);
  assign div = l_q.cfg_s2[CB_DIV_LO +: DIV_W];
  assign tick = master && (l_q.f.div_cnt == div);
  assign rise_ev = active && (master ? (tick && !l_q.f.bclk) : (l_q.bck_s[1] && !l_q.bck_s[2]));
  assign fall_ev = active && (master ? (tick && l_q.f.bclk) : (!l_q.bck_s[1] && l_q.bck_s[2]));
  assign ws_cur = master ? l_q.f.ws_m : l_q.ws_s[1];
  // Receive reads clock and word select back from the pins, so both carry the
  // same two-stage delay as the data input; in master mode that is our own clock
  assign rx_rise = active && l_q.bck_s[1] && !l_q.bck_s[2];
  assign ws_pin = l_q.ws_s[1];
  assign rx_next = {l_q.f.rx_sr[DATA_W-2:0], l_q.sdi_s[1]};

  // Next-state logic; pins are sampled through two stages first
  always_comb begin
    l_d = l_q;
    l_d.rst_s = {l_q.rst_s[0], srst};
    l_d.cfg_s1 = cfg;
    l_d.cfg_s2 = l_q.cfg_s1;
    l_d.bck_s = {l_q.bck_s[1:0], bclk_i};
    l_d.ack_s = {l_q.ack_s[1:0], ack_tgl};
    l_d.ws_s = {l_q.ws_s[0], ws_i};
    l_d.sdi_s = {l_q.sdi_s[0], sdi};
    // Pin directions follow clock source and master/slave choice
    l_d.f.osc_oe = l_q.cfg_s2[CB_MCLK_INT];
    l_d.f.osc = l_q.cfg_s2[CB_MCLK_INT] ? ~l_q.f.osc : 1'h0;
    l_d.f.bclk_oe = master;
    l_d.f.ws_oe = master;
    if (l_q.ack_s[2] ^ l_q.ack_s[1]) begin
      l_d.f.next_w = hold_word;
    end
    // Master: bit clock half period is div+1 link clocks
    if (master && active) begin
      l_d.f.div_cnt = tick ? 8'h00 : l_q.f.div_cnt + 8'h01;
      if (tick) begin
        l_d.f.bclk = ~l_q.f.bclk;
      end
    end
    // Falling edge: advance slot, shift data out
    if (fall_ev) begin
      if (master) begin
        if (l_q.f.bitpos == wlen - 6'h01) begin
          l_d.f.bitpos = 6'h00;
          l_d.f.ws_m = ~l_q.f.ws_m;
        end else begin
          l_d.f.bitpos = l_q.f.bitpos + 6'h01;
        end
      end
      l_d.f.ws_lf = l_q.f.ws_lt;
      // Word select as latched at the last rising edge differs from the one used
      // at the last falling edge: MSB goes out now, one bit after a falling-edge
      // change and half a bit after a rising one
      if (l_q.f.ws_lt != l_q.f.ws_lf && (l_q.f.run || (!l_q.f.ws_lt && l_q.f.pre))) begin
        l_d.f.sdo = l_q.f.next_w[DATA_W-1];
        l_d.f.tx_sr = l_q.f.next_w << 1;
        l_d.f.req = ~l_q.f.req;
        l_d.f.run = 1'h1;
      end else begin
        l_d.f.sdo = l_q.f.tx_sr[DATA_W-1];
        l_d.f.tx_sr = l_q.f.tx_sr << 1;
        // Fetch the first left word during the right slot before it, so the
        // ring's left/right order holds from the very first word
        if (l_q.f.ws_lt != l_q.f.ws_lf && l_q.f.ws_lt && !l_q.f.run) begin
          l_d.f.req = ~l_q.f.req;
          l_d.f.pre = 1'h1;
        end
      end
    end
    // Rising edge: latch word select for the transmit side
    if (rise_ev) begin
      l_d.f.ws_lt = ws_cur;
    end
    // Receive: sample input; first slot of a channel closes the last word
    if (rx_rise) begin
      l_d.f.ws_lr = ws_pin;
      l_d.f.rx_sr = rx_next;
      if (ws_pin != l_q.f.ws_lr && (l_q.f.rx_run || !l_q.f.ws_lr)) begin
        l_d.f.rxw = sap_justify(rx_next, wlen);
        l_d.f.rx_t = ~l_q.f.rx_t;
        l_d.f.rx_run = 1'h1;
      end
    end
    // Disabled or given over to the other output function: stay quiet
    if (!active) begin
      l_d.f.sdo = 1'h0;
      l_d.f.bclk = 1'h0;
      l_d.f.div_cnt = 8'h00;
      l_d.f.bitpos = 6'h00;
      l_d.f.run = 1'h0;
      l_d.f.pre = 1'h0;
      l_d.f.rx_run = 1'h0;
    end
    if (lrst) begin
      l_d.f = '0;
    end
  end

  always_ff @(posedge lclk) begin
    l_q <= l_d;
  end

  // Outputs straight from state
  assign req_tgl = l_q.f.req;
  assign rx_tgl = l_q.f.rx_t;
  assign rx_word = l_q.f.rxw;
  assign bclk_o = l_q.f.bclk;
  assign bclk_oe = l_q.f.bclk_oe;
  assign ws_o = l_q.f.ws_m;
  assign ws_oe = l_q.f.ws_oe;
  assign sdo = l_q.f.sdo;
  assign osc_o = l_q.f.osc;
  assign osc_oe = l_q.f.osc_oe;

  // System reset also disables: the link copy of reset is unknown for its first edges
  a_sdo_on_fall: assert property (@(posedge lclk) disable iff (lrst || srst)
    $changed(l_q.f.sdo) |-> $past(fall_ev) || $past(!active)) else $error("sdo moved off a falling edge");
  a_msb_after_ws: assert property (@(posedge lclk) disable iff (lrst || srst)
    fall_ev && l_q.f.ws_lt != l_q.f.ws_lf && l_q.f.run
    |=> l_q.f.sdo == $past(l_q.f.next_w[DATA_W-1]))
    else $error("MSB not sent after word select change");
  a_ws_word_len: assert property (@(posedge lclk) disable iff (lrst || srst)
    master && $changed(l_q.f.ws_m) |-> $past(fall_ev && l_q.f.bitpos == wlen - 6'h01))
    else $error("word select toggled at wrong slot");
  a_bclk_divide: assert property (@(posedge lclk) disable iff (lrst || srst)
    master && active && $changed(l_q.f.bclk) |-> $past(l_q.f.div_cnt == div))
    else $error("bit clock edge off the divider");
  a_rx_capture: assert property (@(posedge lclk) disable iff (lrst || srst)
    rx_rise && ws_pin != l_q.f.ws_lr && l_q.f.rx_run |=> $changed(l_q.f.rx_t))
    else $error("received word not handed over");
  a_pin_dirs: assert property (@(posedge lclk) disable iff (lrst || srst)
    l_q.f.bclk_oe == l_q.f.ws_oe) else $error("bit clock and word select directions differ");
  a_alt_quiet: assert property (@(posedge lclk) disable iff (lrst || srst)
    !active |=> !l_q.f.sdo) else $error("data out active while disabled");
endmodule

module sap_top import sap_pkg::*; (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic link_clk_port0, // Port 0 link clock
  input wire logic link_clk_port1, // Port 1 link clock
  output logic oversample_clock_port0_out, // Port 0 oversample clock drive
  output logic oversample_clock_port0_oe, // Port 0 oversample clock enable
  output logic oversample_clock_port1_out, // Port 1 oversample clock drive
  output logic oversample_clock_port1_oe, // Port 1 oversample clock enable
  input wire logic bit_clock_port0_in, // Port 0 bit clock pin
  output logic bit_clock_port0_out, // Port 0 bit clock drive
  output logic bit_clock_port0_oe, // Port 0 bit clock enable
  input wire logic bit_clock_port1_in, // Port 1 bit clock pin
  output logic bit_clock_port1_out, // Port 1 bit clock drive
  output logic bit_clock_port1_oe, // Port 1 bit clock enable
  input wire logic word_select_port0_in, // Port 0 word select pin
  output logic word_select_port0_out, // Port 0 word select drive
  output logic word_select_port0_oe, // Port 0 word select enable
  input wire logic word_select_port1_in, // Port 1 word select pin
  output logic word_select_port1_out, // Port 1 word select drive
  output logic word_select_port1_oe, // Port 1 word select enable
  output logic serial_out_port0, // Port 0 serial data out
  output logic serial_out_port1, // Port 1 serial data out
  input wire logic serial_in_port0, // Port 0 serial data in
  input wire logic serial_in_port1 // Port 1 serial data in
);
  typedef struct packed {
    logic [NPORT-1:0][CTRL_W-1:0] ctrl;
    logic [NPORT-1:0][RING_AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [NPORT-1:0][2:0] flags, req_s, rxt_s;
    logic [NPORT-1:0][DATA_W-1:0] hold;
    logic [NPORT-1:0] ack_tgl, rx_pend, tx_pend, fetch;
    logic aw_have, w_have, ar_have, awready, wready, arready, rd_wait, rd_port, bvalid, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
  } sap_sys_t;
  sap_sys_t s_q, s_d;
  logic [DATA_W-1:0] mem_q [NPORT][MEM_DEPTH];
  logic [DATA_W-1:0] m_rd_q [NPORT];
  logic [NPORT-1:0] m_we, busy, req_tgl, rx_tgl;
  logic [NPORT-1:0][RING_AW:0] m_addr;
  logic [NPORT-1:0][DATA_W-1:0] m_wd, rx_word;
  logic wr_go, rd_go, wsel, rsel, wr_done;

  function automatic logic [RING_AW:0] ring_cnt(input logic [RING_AW:0] w, input logic [RING_AW:0] r);
    return w - r;
  endfunction

  always_comb begin
    s_d = s_q;
    m_we = '0;
    m_addr = '0;
    m_wd = '0;
    busy = '0;
    wr_done = 1'h0;
    // Channel handshakes; address and data may arrive in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'h1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'h1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.ar_have = 1'h1;
      s_d.araddr = s_axi_araddr;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'h0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'h0;
    end
    wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    rd_go = s_q.ar_have && !s_q.rvalid && !s_q.rd_wait;
    wsel = s_q.awaddr[2];
    rsel = s_q.araddr[2];
    // Register writes; status clears come before hardware sets so a set wins
    if (wr_go) begin
      case (s_q.awaddr)
        OFS_CTRL0, OFS_CTRL1: begin
          for (int b = 0; b < 2; b++) begin
            if (s_q.wstrb[b]) begin
              s_d.ctrl[wsel][8*b +: 8] = s_q.wdata[8*b +: 8];
            end
          end
          wr_done = 1'h1;
        end
        OFS_STAT0, OFS_STAT1: begin
          if (s_q.wstrb[ST_BYTE]) begin
            s_d.flags[wsel] = s_q.flags[wsel] & ~s_q.wdata[ST_FLAG_LO +: 3];
          end
          wr_done = 1'h1;
        end
        OFS_TXDATA0, OFS_TXDATA1: wr_done = 1'h0;
        default: wr_done = 1'h1;
      endcase
    end
    // Link service per port; it owns the single memory port when it needs it
    for (int p = 0; p < NPORT; p++) begin
      s_d.req_s[p] = {s_q.req_s[p][1:0], req_tgl[p]};
      s_d.rxt_s[p] = {s_q.rxt_s[p][1:0], rx_tgl[p]};
      if (s_q.req_s[p][2] ^ s_q.req_s[p][1]) begin
        s_d.tx_pend[p] = 1'h1;
      end
      if (s_q.rxt_s[p][2] ^ s_q.rxt_s[p][1]) begin
        s_d.rx_pend[p] = 1'h1;
      end
      if (s_q.fetch[p]) begin
        s_d.hold[p] = m_rd_q[p];
        s_d.ack_tgl[p] = ~s_q.ack_tgl[p];
        s_d.fetch[p] = 1'h0;
      end
      if (s_q.rx_pend[p]) begin
        busy[p] = 1'h1;
        s_d.rx_pend[p] = 1'h0;
        if (ring_cnt(s_q.rx_wp[p], s_q.rx_rp[p]) < RING_SIZE) begin
          m_we[p] = 1'h1;
          m_addr[p] = {HALF_RX, s_q.rx_wp[p][RING_AW-1:0]};
          m_wd[p] = rx_word[p];
          s_d.rx_wp[p] = s_q.rx_wp[p] + PTR_ONE;
        end else begin
          s_d.flags[p][F_OVER] = 1'h1;
        end
      end else if (s_q.tx_pend[p] && !s_q.fetch[p]) begin
        busy[p] = 1'h1;
        s_d.tx_pend[p] = 1'h0;
        if (ring_cnt(s_q.tx_wp[p], s_q.tx_rp[p]) != '0) begin
          m_addr[p] = {HALF_TX, s_q.tx_rp[p][RING_AW-1:0]};
          s_d.tx_rp[p] = s_q.tx_rp[p] + PTR_ONE;
          s_d.fetch[p] = 1'h1;
        end else begin
          // Empty ring: send silence rather than stall the link
          s_d.hold[p] = '0;
          s_d.ack_tgl[p] = ~s_q.ack_tgl[p];
          s_d.flags[p][F_UNDER] = 1'h1;
        end
      end
    end
    // Sample push waits while the link holds that port's memory
    if (wr_go && (s_q.awaddr == OFS_TXDATA0 || s_q.awaddr == OFS_TXDATA1) && !busy[wsel]) begin
      wr_done = 1'h1;
      if (ring_cnt(s_q.tx_wp[wsel], s_q.tx_rp[wsel]) < RING_SIZE) begin
        m_we[wsel] = 1'h1;
        m_addr[wsel] = {HALF_TX, s_q.tx_wp[wsel][RING_AW-1:0]};
        m_wd[wsel] = s_q.wdata;
        s_d.tx_wp[wsel] = s_q.tx_wp[wsel] + PTR_ONE;
      end else begin
        s_d.flags[wsel][F_DROP] = 1'h1;
      end
    end
    if (wr_done) begin
      s_d.aw_have = 1'h0;
      s_d.w_have = 1'h0;
      s_d.bvalid = 1'h1;
      s_d.bresp = (s_q.awaddr[ADDR_W-1:5] == '0 && s_q.awaddr[1:0] == '0) ? RESP_OKAY : RESP_SLVERR;
    end
    // Reads; a sample pop costs one extra cycle for the memory
    if (s_q.rd_wait) begin
      s_d.rdata = m_rd_q[s_q.rd_port];
      s_d.rd_wait = 1'h0;
      s_d.ar_have = 1'h0;
      s_d.rvalid = 1'h1;
    end else if (rd_go) begin
      s_d.rdata = '0;
      s_d.rresp = RESP_OKAY;
      s_d.rvalid = 1'h1;
      s_d.ar_have = 1'h0;
      case (s_q.araddr)
        OFS_CTRL0, OFS_CTRL1: s_d.rdata[CTRL_W-1:0] = s_q.ctrl[rsel];
        OFS_STAT0, OFS_STAT1: begin
          s_d.rdata[ST_TXCNT_LO +: 7] = ring_cnt(s_q.tx_wp[rsel], s_q.tx_rp[rsel]);
          s_d.rdata[ST_RXCNT_LO +: 7] = ring_cnt(s_q.rx_wp[rsel], s_q.rx_rp[rsel]);
          s_d.rdata[ST_FLAG_LO +: 3] = s_q.flags[rsel];
        end
        OFS_RXDATA0, OFS_RXDATA1: begin
          // Wait while the link or a sample push holds this port's memory
          if (busy[rsel] || m_we[rsel]) begin
            s_d.rvalid = 1'h0;
            s_d.ar_have = 1'h1;
          end else if (ring_cnt(s_q.rx_wp[rsel], s_q.rx_rp[rsel]) != '0) begin
            m_addr[rsel] = {HALF_RX, s_q.rx_rp[rsel][RING_AW-1:0]};
            s_d.rx_rp[rsel] = s_q.rx_rp[rsel] + PTR_ONE;
            s_d.rd_wait = 1'h1;
            s_d.rd_port = rsel;
            s_d.rvalid = 1'h0;
            s_d.ar_have = 1'h1;
          end
        end
        OFS_TXDATA0, OFS_TXDATA1: s_d.rdata = '0;
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_have;
    s_d.wready = !s_d.w_have;
    s_d.arready = !s_d.ar_have;
    if (srst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // One single-port array per port: lower half transmit, upper half receive
  always_ff @(posedge clk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (m_we[p]) begin
        mem_q[p][m_addr[p]] <= m_wd[p];
      end
      m_rd_q[p] <= mem_q[p][m_addr[p]];
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_arready = s_q.arready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Two identical link engines, each on its own clock
  sap_link u_link0 (
    .lclk(link_clk_port0), .srst(srst), .cfg(s_q.ctrl[0]), .hold_word(s_q.hold[0]),
    .ack_tgl(s_q.ack_tgl[0]), .req_tgl(req_tgl[0]), .rx_tgl(rx_tgl[0]), .rx_word(rx_word[0]),
    .bclk_o(bit_clock_port0_out), .bclk_oe(bit_clock_port0_oe), .bclk_i(bit_clock_port0_in),
    .ws_o(word_select_port0_out), .ws_oe(word_select_port0_oe), .ws_i(word_select_port0_in),
    .sdo(serial_out_port0), .sdi(serial_in_port0),
    .osc_o(oversample_clock_port0_out), .osc_oe(oversample_clock_port0_oe));
  sap_link u_link1 (
    .lclk(link_clk_port1), .srst(srst), .cfg(s_q.ctrl[1]), .hold_word(s_q.hold[1]),
    .ack_tgl(s_q.ack_tgl[1]), .req_tgl(req_tgl[1]), .rx_tgl(rx_tgl[1]), .rx_word(rx_word[1]),
    .bclk_o(bit_clock_port1_out), .bclk_oe(bit_clock_port1_oe), .bclk_i(bit_clock_port1_in),
    .ws_o(word_select_port1_out), .ws_oe(word_select_port1_oe), .ws_i(word_select_port1_in),
    .sdo(serial_out_port1), .sdi(serial_in_port1),
    .osc_o(oversample_clock_port1_out), .osc_oe(oversample_clock_port1_oe));

  a_bresp_hold: assert property (@(posedge clk) disable iff (srst)
    s_q.bvalid && !s_axi_bready |=> s_q.bvalid && $stable(s_q.bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (@(posedge clk) disable iff (srst)
    s_q.rvalid && !s_axi_rready |=> s_q.rvalid && $stable(s_q.rdata)) else $error("rdata dropped");
  a_rx_ring_bound: assert property (@(posedge clk) disable iff (srst)
    ring_cnt(s_q.rx_wp[0], s_q.rx_rp[0]) <= RING_SIZE) else $error("receive ring overfilled");
  a_under_silence: assert property (@(posedge clk) disable iff (srst)
    s_q.tx_pend[0] && !s_q.fetch[0] && !s_q.rx_pend[0] && s_q.tx_wp[0] == s_q.tx_rp[0]
    |=> s_q.hold[0] == '0 && s_q.flags[0][F_UNDER]) else $error("underrun not handled");
endmodule

/* dv/sap_codec.sv */
// Codec model: bit clock source for a slave port, data echo, word capture
module sap_codec (
  input wire logic gen, // Drive bit clock and word select
  input wire logic bclk, // Resolved bit clock wire
  input wire logic ws, // Resolved word select wire
  input wire logic sdo, // Device data out
  input wire logic [5:0] wl, // Bits per word when generating
  output logic bclk_o, // Bit clock drive
  output logic ws_o, // Word select drive
  output logic sdi, // Data into device
  output logic [31:0] left_q, // Last left word seen
  output logic [31:0] right_q // Last right word seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sr = '0;
  logic [5:0] n = '0;
  logic ws_p = 1'b0;
  // Echo, so received words must equal the sent ones
  assign sdi = sdo;
  // Clock stands still low unless asked; word select moves on the falling edge
  initial begin
    bclk_o = 1'b0;
    ws_o = 1'b1;
    forever begin
      for (int i = 0; i < wl; i++) begin
        #120 bclk_o = gen;
        #120 bclk_o = 1'b0;
      end
      if (gen) ws_o = ~ws_o;
    end
  end
  // The bit taken where word select first differs is the last of the old word
  always @(posedge bclk) begin
    if (ws !== ws_p) begin
      if (ws_p) right_q <= {sr[30:0], sdo} << (6'd31 - n);
      else left_q <= {sr[30:0], sdo} << (6'd31 - n);
      sr <= '0;
      n <= '0;
    end else begin
      sr <= {sr[30:0], sdo};
      n <= n + 6'd1;
    end
    ws_p <= ws;
  end
endmodule

/* dv/sap_top_tb.sv */
// Self-checking bench for the stereo audio serial port top
module sap_top_tb;
  import sap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, lc0, lc1, awv, wv, brd, arv, rrd, awr, wrd, bv, arr, rv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdt;
  logic [1:0][31:0] lq, rq;
  logic [1:0] br, rr, bo, boe, wo, woe, oo, ooe, so, pb, pw, pi, gen;
  logic [5:0] gwl;
  wire logic [1:0] bw = (boe & bo) | (~boe & pb);
  wire logic [1:0] ww = (woe & wo) | (~woe & pw);
  int n_errors, compares;
  localparam logic [31:0] LV[4] = '{32'hA5C3_96E1, 32'h8123_4567, 32'hC0DE_F00D, 32'hF0E1_D2C3};
  localparam logic [31:0] RV[4] = '{32'h5A3C_691E, 32'h7EDC_BA98, 32'h3F21_0FF2, 32'h0F1E_2D3C};
  localparam int NB[4] = '{16, 20, 24, 32};
  sap_top dut (.clk(clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .link_clk_port0(lc0),
    .link_clk_port1(lc1), .oversample_clock_port0_out(oo[0]),
    .oversample_clock_port0_oe(ooe[0]), .oversample_clock_port1_out(oo[1]),
    .oversample_clock_port1_oe(ooe[1]), .bit_clock_port0_in(bw[0]),
    .bit_clock_port0_out(bo[0]), .bit_clock_port0_oe(boe[0]), .bit_clock_port1_in(bw[1]),
    .bit_clock_port1_out(bo[1]), .bit_clock_port1_oe(boe[1]), .word_select_port0_in(ww[0]),
    .word_select_port0_out(wo[0]), .word_select_port0_oe(woe[0]),
    .word_select_port1_in(ww[1]), .word_select_port1_out(wo[1]),
    .word_select_port1_oe(woe[1]), .serial_out_port0(so[0]), .serial_out_port1(so[1]),
    .serial_in_port0(pi[0]), .serial_in_port1(pi[1]));
  for (genvar p = 0; p < 2; p++) begin : g_cdc
    sap_codec u_cdc (.gen(gen[p]), .bclk(bw[p]), .ws(ww[p]), .sdo(so[p]), .wl(gwl),
      .bclk_o(pb[p]), .ws_o(pw[p]), .sdi(pi[p]), .left_q(lq[p]), .right_q(rq[p]));
  end
  // System clock, and link clocks; only port 1's is offset so none of its edges lines up with it
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lc0 = 1'b0;
    lc1 = 1'b0;
    fork
      forever #7.5 lc0 = ~lc0;
      begin #3.1 forever #7.5 lc1 = ~lc1; end
    join
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data channels are released each at its own ready
  task automatic wrt(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    fork
      begin do @(posedge clk); while (!awr); awv <= 1'b0; end
      begin do @(posedge clk); while (!wrd); wv <= 1'b0; end
    join
    brd <= 1'b1;
    do @(posedge clk); while (!bv);
    r = br;
    brd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    rrd <= 1'b1;
    do @(posedge clk); while (!rv);
    d = rdt;
    r = rr;
    rrd <= 1'b0;
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog well past the expected run length
  initial begin
    #2_000_000;
    n_errors++;
    close_out();
  end
  initial begin
    logic [31:0] d, c, el, er;
    logic [1:0] r;
    {awv, wv, brd, arv, rrd, awa, ara, wd, gen} = '0;
    srst = 1'b1;
    gwl = 6'h10;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    // One row per word length: master port 0, configured before enabling
    for (int k = 0; k < 4; k++) begin
      el = LV[k] & (32'hFFFF_FFFF << (32 - NB[k]));
      er = RV[k] & (32'hFFFF_FFFF << (32 - NB[k]));
      c = {16'h0000, 8'h01, 2'b00, 2'(k), 4'b0110};
      wrt(OFS_CTRL0, c, r);
      repeat (3) begin
        wrt(OFS_TXDATA0, LV[k], r);
        wrt(OFS_TXDATA0, RV[k], r);
      end
      wrt(OFS_CTRL0, c | 32'h0000_0001, r);
      chk("wr_resp", {30'h0, RESP_OKAY}, {30'h0, r});
      for (int i = 0; i < 3000 && lq[0] !== el; i++) @(posedge clk);
      chk("left0", el, lq[0]);
      for (int i = 0; i < 3000 && rq[0] !== er; i++) @(posedge clk);
      chk("right0", er, rq[0]);
      chk("oe0", 32'h7, {29'h0, ooe[0], woe[0], boe[0]});
      d = '0;
      for (int i = 0; i < 70 && d !== el; i++) rd(OFS_RXDATA0, d, r);
      chk("rx_left0", el, d);
      // The right word lands one word time after the left one
      d = '0;
      for (int i = 0; i < 70 && d == '0; i++) rd(OFS_RXDATA0, d, r);
      chk("rx_right0", er, d);
      // Let the transmit ring run dry so the next row starts on a left word
      d = 32'h0000_0001;
      for (int i = 0; i < 100 && d[6:0] != 7'h00; i++) rd(OFS_STAT0, d, r);
      chk("tx_drained", 32'h0, {25'h0, d[6:0]});
      wrt(OFS_CTRL0, c, r);
      $display("row %0d done", k);
    end
    // Port 1 as slave at 24 bits, clocked by the codec model
    gwl <= 6'h18;
    c = 32'h0000_0020;
    wrt(OFS_CTRL1, c, r);
    repeat (2) begin
      wrt(OFS_TXDATA1, LV[2], r);
      wrt(OFS_TXDATA1, RV[2], r);
    end
    wrt(OFS_CTRL1, c | 32'h0000_0001, r);
    gen <= 2'b10;
    el = LV[2] & 32'hFFFF_FF00;
    for (int i = 0; i < 20000 && lq[1] !== el; i++) @(posedge clk);
    chk("left1", el, lq[1]);
    chk("oe1", 32'h0, {29'h0, ooe[1], woe[1], boe[1]});
    gen <= 2'b00;
    $display("slave port done");
    // Alternate output function keeps the normal port silent
    c = 32'h0000_010E;
    wrt(OFS_CTRL0, c, r);
    wrt(OFS_CTRL0, c | 32'h0000_0001, r);
    d = '0;
    repeat (300) @(posedge clk) d = d | {30'h0, bo[0], so[0]};
    chk("alt_quiet", 32'h0, d);
    $display("alternate output done");
    // Unmapped address is refused on both paths
    wrt(8'h20, 32'h0000_0001, r);
    chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(8'h20, d, r);
    chk("rd_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rd_unmapped_data", 32'h0, d);
    $display("unmapped done");
    close_out();
  end
endmodule
